/* File: rx_phy_core.sv */
// Receive-side MII/RMII pin logic with strap sharing and register slave
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rx_phy_core
  import rx_phy_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_clk,
  input wire logic [3:0] line_nibble,
  input wire logic line_valid,
  input wire logic line_err,
  input wire logic receive_symbol_high_bit,
  input wire logic line_carrier,
  input wire logic line_col,
  input wire logic tx_en,
  input wire logic irq_request,
  input wire logic [3:0] rxd_in,
  output logic [3:0] rxd_out,
  output logic [3:0] rxd_oe,
  output logic rx_er_out,
  output logic rx_dv_out,
  input wire logic rx_clk_in,
  output logic rx_clk_out,
  output logic rx_clk_oe,
  input wire logic col_in,
  output logic col_out,
  output logic col_oe,
  input wire logic crs_in,
  output logic crs_out,
  output logic crs_oe,
  input wire logic intr_in,
  output logic interrupt_output_low,
  output logic intr_oe,
  output logic [2:0] default_mode,
  output logic interrupt_pin_function_strap,
  output logic core_regulator_disable_strap,
  output logic rmii_mode,
  output logic management_address_high_bit,
  output logic tx_error_substitute,
  output logic transmit_symbol_high_bit
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic speed100;
    logic full_duplex;
    logic symbol_mode;
    rx_state_t rstate;
    logic [7:0] sfd_shift;
    logic [3:0] rxd;
    logic rx_er;
    logic rx_dv;
    logic col_pin;
    logic crs;
    logic driven;
    logic [3:0] clk_cnt;
    logic rx_clk;
    logic intr_oe;
    logic tx_err_sub;
    logic tx_sym_hi;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  line_t line_pack;
  rx_path_if bus ();

  // Unmapped or unaligned addresses get an error answer
  function automatic logic [1:0] resp_for(input logic [AXI_AW-1:0] a);
    resp_for = (a == CTRL_ADDR || a == STATUS_ADDR) ? RESP_OKAY
                                                    : RESP_SLVERR;
  endfunction

  assign line_pack = '{nibble: line_nibble, valid: line_valid,
                       err: line_err, sym_hi: receive_symbol_high_bit,
                       carrier: line_carrier, col: line_col,
                       txer_pin: intr_in};

  line_sync u_sync (
    .clk(clk),
    .srst(srst),
    .line_clk(line_clk),
    .line_in(line_pack),
    .bus(bus.sync_src)
  );

  strap_capture u_strap (
    .clk(clk),
    .srst(srst),
    .pins({crs_in, col_in, rx_clk_in, rxd_in}),
    .bus(bus.strap_src)
  );

  logic rmii;
  logic ten;
  logic no_loop;
  logic [7:0] shifted;
  assign rmii = bus.strap.rmii;
  assign ten = ~st.speed100;
  assign no_loop = rmii & ten & ~st.full_duplex & tx_en;
  assign shifted = {bus.line.nibble[1:0], st.sfd_shift[7:2]};

  // Next state of bus slave, control and receive pins
  always_comb begin
    next_st = st;
    // Write address and data are taken independently
    if (st.awready && s_axi_awvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      if (st.aw_addr == CTRL_ADDR && st.w_strb[0]) begin
        next_st.speed100 = st.w_data[CTRL_SPEED_BIT];
        next_st.full_duplex = st.w_data[CTRL_DUPLEX_BIT];
        next_st.symbol_mode = st.w_data[CTRL_SYMBOL_BIT];
      end
      next_st.bvalid = 1'b1;
      next_st.bresp = resp_for(st.aw_addr);
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
    end
    // Reads answer one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (st.arready && s_axi_arvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = resp_for(s_axi_araddr);
      next_st.rdata = '0;
      if (s_axi_araddr == CTRL_ADDR) begin
        next_st.rdata[CTRL_SPEED_BIT] = st.speed100;
        next_st.rdata[CTRL_DUPLEX_BIT] = st.full_duplex;
        next_st.rdata[CTRL_SYMBOL_BIT] = st.symbol_mode;
      end else if (s_axi_araddr == STATUS_ADDR) begin
        next_st.rdata[ST_MODE_LSB +: 3] = bus.strap.mode;
        next_st.rdata[ST_INTSEL_BIT] = bus.strap.int_sel;
        next_st.rdata[ST_REG_DIS_BIT] = bus.strap.reg_off;
        next_st.rdata[ST_RMII_BIT] = bus.strap.rmii;
        next_st.rdata[ST_ADDR4_BIT] = bus.strap.addr4;
        next_st.rdata[ST_DONE_BIT] = bus.strap_done;
        next_st.rdata[ST_STATE_LSB +: 2] = st.rstate;
      end
    end
    next_st.awready = ~next_st.aw_held;
    next_st.wready = ~next_st.w_held;
    next_st.arready = ~next_st.rvalid;

    // Framing: 10BASE-T over RMII hunts for the delimiter first
    case (st.rstate)
      RX_IDLE: begin
        next_st.sfd_shift = '0;
        if (bus.line.carrier) begin
          next_st.rstate = (rmii && ten) ? RX_PREAMBLE : RX_DATA;
        end
      end
      RX_PREAMBLE: begin
        if (!bus.line.carrier) begin
          next_st.rstate = RX_IDLE;
        end else if (bus.line_edge) begin
          next_st.sfd_shift = shifted;
          if (shifted == SFD_BYTE) begin
            next_st.rstate = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (!bus.line.carrier) begin
          next_st.rstate = RX_IDLE;
        end
      end
      default: begin
        next_st.rstate = RX_IDLE;
      end
    endcase

    // Data pins move only on line clock edges
    if (bus.line_edge) begin
      if (rmii) begin
        next_st.rxd = '0;
        if (st.rstate == RX_DATA && !no_loop) begin
          next_st.rxd[1:0] = bus.line.nibble[1:0];
        end
        next_st.rx_dv = 1'b0;
      end else begin
        next_st.rxd = bus.line.nibble;
        next_st.rx_dv = bus.line.valid;
      end
      next_st.rx_er = (st.symbol_mode && !rmii) ? bus.line.sym_hi
                                                : bus.line.err;
    end
    // Shared collision pin carries carrier/valid in RMII
    next_st.col_pin = rmii ? bus.line.carrier : bus.line.col;
    next_st.crs = bus.line.carrier;
    next_st.driven = bus.strap_done;

    // Receive clock divider; at 25MHz base the fast rate is capped
    if (rmii) begin
      next_st.rx_clk = 1'b0;
      next_st.clk_cnt = '0;
    end else if (st.clk_cnt >=
                 (st.speed100 ? RX_HALF_100 : RX_HALF_10) - 4'h1) begin
      next_st.rx_clk = ~st.rx_clk;
      next_st.clk_cnt = '0;
    end else begin
      next_st.clk_cnt = st.clk_cnt + 4'h1;
    end

    // Shared interrupt / transmit error pin by strap
    if (bus.strap.int_sel) begin
      next_st.intr_oe = bus.strap_done & irq_request;
      next_st.tx_err_sub = 1'b0;
      next_st.tx_sym_hi = 1'b0;
    end else begin
      next_st.intr_oe = 1'b0;
      next_st.tx_err_sub = bus.line.txer_pin & st.speed100 &
                           ~st.symbol_mode;
      next_st.tx_sym_hi = bus.line.txer_pin & st.symbol_mode;
    end
  end

  // Register stage; strap pins stay undriven through reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.speed100 <= CTRL_SPEED_RST;
      st.rstate <= RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
  assign rxd_out = st.rxd;
  assign rxd_oe = {4{st.driven}};
  assign rx_er_out = st.rx_er;
  assign rx_dv_out = st.rx_dv;
  assign rx_clk_out = st.rx_clk;
  assign rx_clk_oe = st.driven;
  assign col_out = st.col_pin;
  assign col_oe = st.driven;
  assign crs_out = st.crs;
  assign crs_oe = st.driven;
  // Open-drain style: pin only ever pulled low
  assign interrupt_output_low = 1'b0;
  assign intr_oe = st.intr_oe;
  assign default_mode = bus.strap.mode;
  assign interrupt_pin_function_strap = bus.strap.int_sel;
  assign core_regulator_disable_strap = bus.strap.reg_off;
  assign rmii_mode = bus.strap.rmii;
  assign management_address_high_bit = bus.strap.addr4;
  assign tx_error_substitute = st.tx_err_sub;
  assign transmit_symbol_high_bit = st.tx_sym_hi;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence high_ten;
    st.rx_clk [*5] ##1 !st.rx_clk;
  endsequence

  chk_nibble_mii_pass: assert property (
    bus.line_edge && !rmii |=> st.rxd == $past(bus.line.nibble))
    else $error("nibble not presented in MII");
  chk_rmii_upper_low: assert property (
    bus.strap_done && rmii |-> ##1 st.rxd[3:2] == 2'h0)
    else $error("upper data lines used in RMII");
  chk_rx_er_error: assert property (
    bus.line_edge && !st.symbol_mode && bus.line.err |=> st.rx_er)
    else $error("receive error not raised");
  chk_rx_er_symbol: assert property (
    bus.line_edge && st.symbol_mode && !rmii
    |=> st.rx_er == $past(bus.line.sym_hi))
    else $error("symbol high bit not on error pin");
  chk_dv_mode_use: assert property (
    bus.line_edge |=> st.rx_dv == ($past(bus.line.valid) && !rmii))
    else $error("receive valid wrong for mode");
  chk_rx_clk_ten: assert property (
    $rose(st.rx_clk) && !st.speed100 && !rmii |-> high_ten)
    else $error("10BASE-T receive clock half period wrong");
  chk_sfd_data_hold: assert property (
    bus.line_edge && rmii && st.rstate == RX_PREAMBLE
    |=> st.rxd[1:0] == 2'h0)
    else $error("data before delimiter");
  chk_no_tx_loop: assert property (
    bus.line_edge && no_loop |=> st.rxd[1:0] == 2'h0)
    else $error("transmit data looped back");
  chk_col_crs_dv: assert property (
    rmii |=> st.col_pin == $past(bus.line.carrier))
    else $error("carrier/valid not following medium");
  chk_carrier_sense: assert property (
    1'b1 |=> st.crs == $past(bus.line.carrier))
    else $error("carrier sense lost");
  chk_txer_substitute: assert property (
    !bus.strap.int_sel && bus.line.txer_pin && !st.speed100
    |=> !st.tx_err_sub)
    else $error("transmit error used in 10BASE-T");
endmodule // rx_phy_core
`default_nettype wire

/* File: rx_phy_pkg.sv */
// Shared constants and types for the receive-side MII/RMII block
// What this block does
// - Receive nibble on four lines, line0 LSB
// - Reset samples data lines 0-2 as mode
// - RMII leaves receive data lines 2,3 unused
// - Line 3 high/floating selects interrupt output
// - Line 3 low selects transmit error input
// - Receive error flags errors in current frame
// - Symbol mode puts symbol MSB on error in MII
// - MII valid marks decoded nibbles; RMII unused
// - MII receive clock 12.5MHz (25MHz capped) or 2.5MHz
// - Clock pin strap pulled up disables regulator
// - MII collision output follows medium collision
// - Reset release latches MII/RMII select strap
// - RMII carrier/valid high while medium busy
// - RMII 10BASE-T data low until SFD
// - No transmit loopback in RMII 10BASE-T half-duplex
// - Carrier sense output follows medium carrier
// - Transmit error substitutes error code-group
// - Carrier pin strap is address bit 4
package rx_phy_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int RX_CLK_100_HZ = 25_000_000;
  localparam int RX_CLK_10_HZ = 2_500_000;
  localparam int RX_HALF_100_RAW = CLK_HZ / (2 * RX_CLK_100_HZ);
  localparam int RX_HALF_10_RAW = CLK_HZ / (2 * RX_CLK_10_HZ);
  localparam logic [3:0] RX_HALF_100 =
    (RX_HALF_100_RAW < 1) ? 4'h1 : 4'(RX_HALF_100_RAW);
  localparam logic [3:0] RX_HALF_10 =
    (RX_HALF_10_RAW < 1) ? 4'h1 : 4'(RX_HALF_10_RAW);
  localparam logic [7:0] SFD_BYTE = 8'hAB;
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] CTRL_ADDR = 4'h0;
  localparam logic [AXI_AW-1:0] STATUS_ADDR = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_SPEED_BIT = 0;
  localparam int CTRL_DUPLEX_BIT = 1;
  localparam int CTRL_SYMBOL_BIT = 2;
  localparam logic CTRL_SPEED_RST = 1'b1;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_INTSEL_BIT = 3;
  localparam int ST_REG_DIS_BIT = 4;
  localparam int ST_RMII_BIT = 5;
  localparam int ST_ADDR4_BIT = 6;
  localparam int ST_DONE_BIT = 7;
  localparam int ST_STATE_LSB = 8;
  localparam int PIN_RXCLK = 4;
  localparam int PIN_COL = 5;
  localparam int PIN_CRS = 6;
  localparam int STRAP_PINS = 7;
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_PREAMBLE = 2'h1,
    RX_DATA = 2'h3
  } rx_state_t;
  typedef struct packed {
    logic [2:0] mode;
    logic int_sel;
    logic reg_off;
    logic rmii;
    logic addr4;
  } strap_t;
  localparam strap_t STRAP_RST = '0;
  typedef struct packed {
    logic [3:0] nibble;
    logic valid;
    logic err;
    logic sym_hi;
    logic carrier;
    logic col;
    logic txer_pin;
  } line_t;
endpackage

/* File: rx_path_if.sv */
// Carrier for synced line signals and latched straps
`timescale 1ns/1ps
`default_nettype none
interface rx_path_if;
  import rx_phy_pkg::*;
  line_t line;
  logic line_edge;
  strap_t strap;
  logic strap_done;
  modport sync_src (output line, output line_edge);
  modport strap_src (output strap, output strap_done);
  modport core (input line, input line_edge, input strap, input strap_done);
endinterface
`default_nettype wire

/* File: line_sync.sv */
// Two-stage synchroniser and edge finder for the line side
`timescale 1ns/1ps
`default_nettype none
module line_sync
  import rx_phy_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic line_clk,
  input wire line_t line_in,
  rx_path_if.sync_src bus
);
  typedef struct packed {
    line_t s1;
    line_t s2;
    logic c1;
    logic c2;
    logic c3;
  } sync_state_t;
  sync_state_t st;
  sync_state_t next_st;

  // First stages feed only the second stages
  always_comb begin
    next_st = st;
    next_st.s1 = line_in;
    next_st.s2 = st.s1;
    next_st.c1 = line_clk;
    next_st.c2 = st.c1;
    next_st.c3 = st.c2;
    // Clock stages keep sampling in reset: a line clock left high
    // would otherwise look like a fresh rise right after release
    if (srst) begin
      next_st.s1 = '0;
      next_st.s2 = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // Data is sampled alongside the clock so both share one latency
  assign bus.line = st.s2;
  assign bus.line_edge = st.c2 & ~st.c3;
endmodule // line_sync
`default_nettype wire

/* File: strap_capture.sv */
// Reset-time strap sampling on the shared receive pins
`timescale 1ns/1ps
`default_nettype none
module strap_capture
  import rx_phy_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [STRAP_PINS-1:0] pins,
  rx_path_if.strap_src bus
);
  typedef struct packed {
    logic [STRAP_PINS-1:0] s1;
    logic [STRAP_PINS-1:0] s2;
    logic rst_d;
    strap_t strap;
    logic done;
  } cap_state_t;
  cap_state_t st;
  cap_state_t next_st;

  // Samplers keep running in reset: the straps are only valid then
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.rst_d = srst;
    if (srst) begin
      next_st.strap = STRAP_RST;
      next_st.done = 1'b0;
    end else if (st.rst_d) begin
      next_st.strap.mode = st.s2[2:0];
      next_st.strap.int_sel = st.s2[3];
      next_st.strap.reg_off = st.s2[PIN_RXCLK];
      next_st.strap.rmii = st.s2[PIN_COL];
      next_st.strap.addr4 = st.s2[PIN_CRS];
      next_st.done = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign bus.strap = st.strap;
  assign bus.strap_done = st.done;

  chk_strap_latch_mode: assert property (
    @(posedge clk) disable iff (srst)
    st.rst_d |=> st.strap.mode == $past(st.s2[2:0]))
    else $error("mode strap not latched at release");
  chk_strap_hold_value: assert property (
    @(posedge clk) disable iff (srst)
    st.done |=> $stable(st.strap))
    else $error("strap changed after latch");
  chk_rmii_latch_sel: assert property (
    @(posedge clk) disable iff (srst)
    st.rst_d |=> st.strap.rmii == $past(st.s2[PIN_COL]) && st.done)
    else $error("rmii select not latched");
endmodule // strap_capture
`default_nettype wire

/* File: mac_model.sv */
// Far-side MAC and board model: resolves the shared receive pins
`timescale 1ns/1ps
`default_nettype none
module mac_model
  import rx_phy_pkg::*;
(
  input wire strap_t strap,
  input wire logic txer_en,
  input wire logic txer,
  input wire logic [3:0] rxd_out,
  input wire logic [3:0] rxd_oe,
  input wire logic rx_clk_out,
  input wire logic rx_clk_oe,
  input wire logic col_out,
  input wire logic col_oe,
  input wire logic crs_out,
  input wire logic crs_oe,
  input wire logic intr_oe,
  output logic [3:0] rxd_in,
  output logic rx_clk_in,
  output logic col_in,
  output logic crs_in,
  output logic intr_in
);
  // A released pin settles to its strap resistor, never to the last value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rxd_in[i] = rxd_oe[i] ? rxd_out[i] : strap.mode[i];
    end
    rxd_in[3] = rxd_oe[3] ? rxd_out[3] : strap.int_sel;
    rx_clk_in = rx_clk_oe ? rx_clk_out : strap.reg_off;
    col_in = col_oe ? col_out : strap.rmii;
    crs_in = crs_oe ? crs_out : strap.addr4;
    // MAC drives transmit error only when asked; the line 3 strap resistor wins otherwise
    intr_in = intr_oe ? 1'h0 : (txer_en ? txer : strap.int_sel);
  end
  // Error and valid are only listened to, never driven during reset
  // Receive error is not relied upon in RMII
endmodule // mac_model
`default_nettype wire

/* File: phy_mii_rmii_receive_straps_test.sv */
// Self-checking bench for the receive pin block and its straps
`timescale 1ns/1ps
`default_nettype none
module phy_mii_rmii_receive_straps_test;
  import rx_phy_pkg::*;
  // Row: line nibble, {valid,err}, expected rxd, expected {dv,er}
  typedef struct packed {
    logic [3:0] nib;
    logic [3:0] ve;
    logic [3:0] xd;
    logic [3:0] xve;
  } row_t;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [AXI_AW-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic line_clk = 1'h0, line_valid = 1'h0, line_err = 1'h0;
  logic [3:0] line_nibble = 4'h0;
  logic receive_symbol_high_bit = 1'h0, line_carrier = 1'h0;
  logic line_col = 1'h0, tx_en = 1'h0, irq_request = 1'h0;
  logic [3:0] rxd_in, rxd_out, rxd_oe;
  logic rx_er_out, rx_dv_out, rx_clk_in, rx_clk_out, rx_clk_oe;
  logic col_in, col_out, col_oe, crs_in, crs_out, crs_oe;
  logic intr_in, interrupt_output_low, intr_oe;
  logic [2:0] default_mode;
  logic interrupt_pin_function_strap, core_regulator_disable_strap;
  logic rmii_mode, management_address_high_bit;
  logic tx_error_substitute, transmit_symbol_high_bit;
  strap_t strap = STRAP_RST;
  logic txer_en = 1'h0, txer = 1'h0;
  int fails = 0;
  int checks = 0;
  // Last strap row is MII with the interrupt function, used afterwards
  strap_t straps [4] = '{7'h26, 7'h54, 7'h0B, 7'h79};
  // MII frame, RMII 10BASE-T frame, then the same with own transmit
  row_t rows [26] = '{
    16'h1212, 16'h2222, 16'h4242, 16'h8383, 16'h5252, 16'hA2A2, 16'h0000,
    16'hD200, 16'hD200, 16'hD200, 16'hD200, 16'hF200, 16'hE200,
    16'hE200, 16'hE200, 16'hE220, 16'hD210, 16'hF331, 16'hC000,
    16'hF200, 16'hE200, 16'hE200, 16'hE200, 16'hE200, 16'hD200, 16'hC000
  };

  rx_phy_core u_rx_phy_core (
    .clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .line_clk, .line_nibble, .line_valid,
    .line_err, .receive_symbol_high_bit, .line_carrier, .line_col,
    .tx_en, .irq_request, .rxd_in, .rxd_out, .rxd_oe, .rx_er_out,
    .rx_dv_out, .rx_clk_in, .rx_clk_out, .rx_clk_oe, .col_in, .col_out,
    .col_oe, .crs_in, .crs_out, .crs_oe, .intr_in, .interrupt_output_low,
    .intr_oe, .default_mode, .interrupt_pin_function_strap,
    .core_regulator_disable_strap, .rmii_mode,
    .management_address_high_bit, .tx_error_substitute,
    .transmit_symbol_high_bit
  );
  mac_model u_mac_model (
    .strap, .txer_en, .txer, .rxd_out, .rxd_oe, .rx_clk_out, .rx_clk_oe,
    .col_out, .col_oe, .crs_out, .crs_oe, .intr_oe, .rxd_in, .rx_clk_in,
    .col_in, .crs_in, .intr_in
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic guard(input logic ok);
    if (ok !== 1'h1) begin
      fails++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out();
    end
  endtask

  // Wait edges, then step off the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic axi(input logic wr, input logic [AXI_AW-1:0] a,
      input logic [31:0] d, input logic [31:0] m, input logic [1:0] er);
    int n;
    logic pa;
    logic pw;
    logic ta;
    logic tw;
    pa = 1'h1;
    pw = wr;
    n = 0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    // Ready is read before the edge that takes the item, then released
    while ((pa || pw) && n < 50) begin
      ta = pa && (wr ? s_axi_awready : s_axi_arready);
      tw = pw && s_axi_wready;
      cyc(1);
      n++;
      if (ta) begin
        pa = 1'h0;
        s_axi_awvalid <= 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (tw) begin
        pw = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'h1 && n < 50) begin
      cyc(1);
      n++;
    end
    guard(n < 50);
    if (wr) begin
      check(s_axi_bresp, er);
    end else begin
      check(s_axi_rresp, er);
      check(s_axi_rdata & m, d & m);
    end
    cyc(1);
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    cyc(1);
  endtask

  task automatic do_reset(input strap_t s);
    strap <= s;
    srst <= 1'h1;
    cyc(16);
    check(rxd_oe, 4'h0);
    check(rx_er_out, 1'h0);
    check(rx_dv_out, 1'h0);
    check({rx_clk_oe, col_oe, crs_oe}, 3'h0);
    srst <= 1'h0;
    cyc(3);
    check({rxd_oe, rx_clk_oe, col_oe, crs_oe}, 7'h7F);
  endtask

  // Period of the receive clock, second to third rise, to avoid a ramp
  task automatic clk_per(input int exp);
    int n;
    int k;
    int t;
    logic l;
    n = 0;
    k = 0;
    l = rx_clk_out;
    for (t = 0; t < 60 && k < 3; t++) begin
      cyc(1);
      n++;
      if (rx_clk_out === 1'h1 && l === 1'h0) begin
        k++;
        if (k < 3) n = 0;
      end
      l = rx_clk_out;
    end
    guard(k == 3);
    check(n, exp);
  endtask

  // One 320 ns line period; the previous row is checked one cycle into the low half,
  // well after its answer landed and before the next rise is seen
  task automatic tick(input row_t r, input row_t p, input logic c);
    line_clk <= 1'h0;
    line_nibble <= r.nib;
    line_valid <= r.ve[1];
    line_err <= r.ve[0];
    cyc(1);
    if (c) begin
      check(rxd_out, p.xd);
      check(rx_dv_out, p.xve[1]);
      check(rx_er_out, p.xve[0]);
    end
    cyc(3);
    line_clk <= 1'h1;
    cyc(4);
  endtask

  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      tick(rows[i], rows[(i > lo) ? i - 1 : i], i > lo);
    end
  endtask

  initial begin
    for (int j = 0; j < 4; j++) begin
      strap_t s;
      s = straps[j];
      do_reset(s);
      check(default_mode, s.mode);
      check(interrupt_pin_function_strap, s.int_sel);
      check(core_regulator_disable_strap, s.reg_off);
      check(rmii_mode, s.rmii);
      check(management_address_high_bit, s.addr4);
      axi(1'h0, STATUS_ADDR, {24'h0, 1'h1, s.addr4, s.rmii, s.reg_off,
          s.int_sel, s.mode}, 32'hFF, RESP_OKAY);
      if (s.int_sel) begin
        irq_request <= 1'h1;
        cyc(2);
        check(intr_oe, 1'h1);
        check(interrupt_output_low, 1'h0);
        irq_request <= 1'h0;
      end else begin
        txer_en <= 1'h1;
        txer <= 1'h1;
        cyc(4);
        check(tx_error_substitute, 1'h1);
        axi(1'h1, CTRL_ADDR, 32'h4, 32'h0, RESP_OKAY);
        check(transmit_symbol_high_bit, 1'h1);
        check(tx_error_substitute, 1'h0);
        txer_en <= 1'h0;
      end
      cyc(4);
      check(intr_oe, 1'h0);
      check(default_mode, s.mode);
    end
    axi(1'h0, CTRL_ADDR, 32'h1, 32'h7, RESP_OKAY);
    axi(1'h0, 4'h8, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axi(1'h1, 4'hC, 32'h0, 32'h0, RESP_SLVERR);
    // Fastest reachable receive clock is half the system clock
    clk_per(2);
    check(rx_clk_oe, 1'h1);
    line_carrier <= 1'h1;
    line_col <= 1'h1;
    run_rows(0, 6);
    check(crs_out, 1'h1);
    check(col_out, 1'h1);
    axi(1'h1, CTRL_ADDR, 32'h5, 32'h0, RESP_OKAY);
    axi(1'h0, CTRL_ADDR, 32'h5, 32'h7, RESP_OKAY);
    receive_symbol_high_bit <= 1'h1;
    tick(rows[0], rows[0], 1'h0);
    tick(rows[1], rows[0], 1'h0);
    check(rx_er_out, 1'h1);
    // Collision outlasts carrier so the two MII pins are told apart
    line_carrier <= 1'h0;
    receive_symbol_high_bit <= 1'h0;
    cyc(5);
    check(crs_out, 1'h0);
    check(col_out, 1'h1);
    axi(1'h1, CTRL_ADDR, 32'h0, 32'h0, RESP_OKAY);
    clk_per(10);
    line_col <= 1'h0;
    do_reset(straps[0]);
    axi(1'h1, CTRL_ADDR, 32'h2, 32'h0, RESP_OKAY);
    line_carrier <= 1'h1;
    run_rows(7, 18);
    check(col_out, 1'h1);
    check(rx_clk_out, 1'h0);
    line_carrier <= 1'h0;
    axi(1'h1, CTRL_ADDR, 32'h0, 32'h0, RESP_OKAY);
    tx_en <= 1'h1;
    line_carrier <= 1'h1;
    run_rows(19, 25);
    close_out();
  end
endmodule // phy_mii_rmii_receive_straps_test
`default_nettype wire
